// ==== rtl/analog_comparator_control.sv ====
`timescale 1ns/1ns
`default_nettype none

module analog_comparator_control
    import cmp_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator core
    input wire logic cmp_raw,
    output logic cmp_power_off,
    output logic cmp_bandgap_select,
    // Negative input selection
    output logic cmp_neg_from_mux,
    output logic [3:0] cmp_neg_channel,
    // Timer capture front end
    output logic cmp_capture_out,
    // Interrupt request and vector acknowledge
    input wire logic irq_ack,
    output logic cmp_irq_req
);

    // ------------------------------------------------------------
    // Synchroniser and edge detection
    // ------------------------------------------------------------
    cmp_event_if ev ();

    cmp_sync_edge u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .cmp_raw(cmp_raw),
        .ev(ev.source)
    );

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    logic power_off;
    logic bandgap;
    logic irq_flag;
    logic irq_enable;
    logic capture_route;
    irq_mode_t irq_mode;
    logic mux_enable;
    logic chan_sel_hi;
    // Trigger source is only stored and read back here
    logic [2:0] adc_trigger_src;
    logic adc_enable;
    logic adc_power_reduce;
    logic [2:0] chan_sel_lo;
    logic global_ie;

    logic next_power_off;
    logic next_bandgap;
    logic next_irq_flag;
    logic next_irq_enable;
    logic next_capture_route;
    irq_mode_t next_irq_mode;
    logic next_mux_enable;
    logic next_chan_sel_hi;
    logic [2:0] next_adc_trigger_src;
    logic next_adc_enable;
    logic next_adc_power_reduce;
    logic [2:0] next_chan_sel_lo;
    logic next_global_ie;

    logic wr_commit;
    logic hit_ccs;
    logic hit_acsb;
    logic hit_aux;
    logic cmp_event;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Full-address compare: any other offset answers with an error
    assign hit_ccs = (paddr == ADDR_CMP_CTRL_STATUS);
    assign hit_acsb = (paddr == ADDR_ADC_CTRL_STATUS_B);
    assign hit_aux = (paddr == ADDR_CMP_AUX_CONTROL);
    // Writes land only on the edge where the access completes
    assign wr_commit = psel & penable & pready & pwrite;

    // ------------------------------------------------------------
    // Interrupt event select
    // ------------------------------------------------------------
    // Reserved code selects no event, so the flag never sets in it
    always_comb begin
        case (irq_mode)
            MODE_TOGGLE: cmp_event = ev.toggle;
            MODE_FALL: cmp_event = ev.fall;
            MODE_RISE: cmp_event = ev.rise;
            default: cmp_event = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------
    always_comb begin
        next_power_off = power_off;
        next_bandgap = bandgap;
        next_irq_enable = irq_enable;
        next_capture_route = capture_route;
        next_irq_mode = irq_mode;
        next_mux_enable = mux_enable;
        next_chan_sel_hi = chan_sel_hi;
        next_adc_trigger_src = adc_trigger_src;
        next_adc_enable = adc_enable;
        next_adc_power_reduce = adc_power_reduce;
        next_chan_sel_lo = chan_sel_lo;
        next_global_ie = global_ie;
        next_irq_flag = irq_flag;
        if (wr_commit && hit_ccs) begin
            next_power_off = pwdata[BIT_POWER_OFF];
            next_bandgap = pwdata[BIT_BANDGAP];
            next_irq_enable = pwdata[BIT_IRQ_ENABLE];
            next_capture_route = pwdata[BIT_CAPTURE];
            next_irq_mode = irq_mode_t'({pwdata[BIT_MODE_HI], pwdata[BIT_MODE_LO]});
            if (pwdata[BIT_IRQ_FLAG]) begin
                next_irq_flag = 1'b0;
            end
        end
        if (wr_commit && hit_acsb) begin
            next_mux_enable = pwdata[BIT_MUX_ENABLE];
            next_chan_sel_hi = pwdata[BIT_CHAN_HI];
            next_adc_trigger_src = pwdata[TRIG_MSB:TRIG_LSB];
        end
        if (wr_commit && hit_aux) begin
            next_adc_enable = pwdata[BIT_ADC_ENABLE];
            next_adc_power_reduce = pwdata[BIT_ADC_POWER_REDUCE];
            next_chan_sel_lo = pwdata[CHAN_LO_MSB:CHAN_LO_LSB];
            next_global_ie = pwdata[BIT_GLOBAL_IE];
        end
        // Vector taken clears the flag as a write of one would
        if (irq_ack) begin
            next_irq_flag = 1'b0;
        end
        // A same-cycle event beats either clear so no edge is lost
        if (cmp_event) begin
            next_irq_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_off <= 1'b0;
            bandgap <= 1'b0;
            irq_flag <= 1'b0;
            irq_enable <= 1'b0;
            capture_route <= 1'b0;
            irq_mode <= MODE_TOGGLE;
            mux_enable <= 1'b0;
            chan_sel_hi <= 1'b0;
            adc_trigger_src <= TRIG_RESET;
            adc_enable <= 1'b0;
            adc_power_reduce <= 1'b0;
            chan_sel_lo <= CHAN_LO_RESET;
            global_ie <= 1'b0;
        end else begin
            power_off <= next_power_off;
            bandgap <= next_bandgap;
            irq_flag <= next_irq_flag;
            irq_enable <= next_irq_enable;
            capture_route <= next_capture_route;
            irq_mode <= next_irq_mode;
            mux_enable <= next_mux_enable;
            chan_sel_hi <= next_chan_sel_hi;
            adc_trigger_src <= next_adc_trigger_src;
            adc_enable <= next_adc_enable;
            adc_power_reduce <= next_adc_power_reduce;
            chan_sel_lo <= next_chan_sel_lo;
            global_ie <= next_global_ie;
        end
    end

    // ------------------------------------------------------------
    // Analog side outputs
    // ------------------------------------------------------------
    logic next_cmp_power_off;
    logic next_cmp_bandgap_select;
    logic next_cmp_neg_from_mux;
    logic [3:0] next_cmp_neg_channel;
    logic next_cmp_capture_out;
    logic next_cmp_irq_req;

    always_comb begin
        // Synchroniser keeps running while off; the core holds its level
        next_cmp_power_off = next_power_off;
        next_cmp_bandgap_select = next_bandgap;
        // Mux is the ADC's: only usable while the ADC is off and powered
        next_cmp_neg_from_mux = next_mux_enable & ~next_adc_enable
            & ~next_adc_power_reduce;
        next_cmp_neg_channel = {next_chan_sel_hi, next_chan_sel_lo};
        next_cmp_capture_out = capture_route & ev.result;
        // Request trails the flag and the enables by one cycle
        next_cmp_irq_req = irq_flag & irq_enable & global_ie;
    end

    // Each output is a flop so the analog side sees no glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_power_off <= 1'b0;
            cmp_bandgap_select <= 1'b0;
            cmp_neg_from_mux <= 1'b0;
            cmp_neg_channel <= 4'h0;
            cmp_capture_out <= 1'b0;
            cmp_irq_req <= 1'b0;
        end else begin
            cmp_power_off <= next_cmp_power_off;
            cmp_bandgap_select <= next_cmp_bandgap_select;
            cmp_neg_from_mux <= next_cmp_neg_from_mux;
            cmp_neg_channel <= next_cmp_neg_channel;
            cmp_capture_out <= next_cmp_capture_out;
            cmp_irq_req <= next_cmp_irq_req;
        end
    end

    // ------------------------------------------------------------
    // APB read path and completion
    // ------------------------------------------------------------
    // One wait state keeps pready, prdata and pslverr registered
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic [31:0] rd_word;

    always_comb begin
        // Unmapped offsets and unused bits read as zero
        rd_word = RDATA_ZERO;
        if (hit_ccs) begin
            rd_word[BIT_POWER_OFF] = power_off;
            rd_word[BIT_BANDGAP] = bandgap;
            rd_word[BIT_RESULT] = ev.result;
            rd_word[BIT_IRQ_FLAG] = irq_flag;
            rd_word[BIT_IRQ_ENABLE] = irq_enable;
            rd_word[BIT_CAPTURE] = capture_route;
            rd_word[BIT_MODE_HI] = irq_mode[1];
            rd_word[BIT_MODE_LO] = irq_mode[0];
        end else if (hit_acsb) begin
            rd_word[BIT_MUX_ENABLE] = mux_enable;
            rd_word[BIT_CHAN_HI] = chan_sel_hi;
            rd_word[TRIG_MSB:TRIG_LSB] = adc_trigger_src;
        end else if (hit_aux) begin
            rd_word[BIT_ADC_ENABLE] = adc_enable;
            rd_word[BIT_ADC_POWER_REDUCE] = adc_power_reduce;
            rd_word[CHAN_LO_MSB:CHAN_LO_LSB] = chan_sel_lo;
            rd_word[BIT_GLOBAL_IE] = global_ie;
        end
    end

    always_comb begin
        // Completion is a pulse; a held access repeats it every other cycle
        next_pready = psel & penable & ~pready;
        next_pslverr = 1'b0;
        next_prdata = RDATA_ZERO;
        if (psel && penable && !pready) begin
            next_pslverr = ~(hit_ccs | hit_acsb | hit_aux);
            if (!pwrite) begin
                next_prdata = rd_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RDATA_ZERO;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

endmodule : analog_comparator_control

`default_nettype wire

// ==== rtl/cmp_ctrl_pkg.sv ====
package cmp_ctrl_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CMP_CTRL_STATUS = 12'h050;
    localparam logic [11:0] IDX_ADC_CTRL_STATUS_B = 12'h07b;
    localparam logic [11:0] IDX_CMP_AUX_CONTROL = 12'h080;
    localparam logic [11:0] ADDR_CMP_CTRL_STATUS = IDX_CMP_CTRL_STATUS << 2;
    localparam logic [11:0] ADDR_ADC_CTRL_STATUS_B = IDX_ADC_CTRL_STATUS_B << 2;
    localparam logic [11:0] ADDR_CMP_AUX_CONTROL = IDX_CMP_AUX_CONTROL << 2;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // comparator_control_status fields
    // ------------------------------------------------------------
    localparam int BIT_POWER_OFF = 7;
    localparam int BIT_BANDGAP = 6;
    localparam int BIT_RESULT = 5;
    localparam int BIT_IRQ_FLAG = 4;
    localparam int BIT_IRQ_ENABLE = 3;
    localparam int BIT_CAPTURE = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;

    // ------------------------------------------------------------
    // adc_control_status_b fields
    // ------------------------------------------------------------
    localparam int BIT_MUX_ENABLE = 6;
    localparam int BIT_CHAN_HI = 3;
    localparam int TRIG_MSB = 2;
    localparam int TRIG_LSB = 0;

    // ------------------------------------------------------------
    // cmp_aux_control fields
    // ------------------------------------------------------------
    localparam int BIT_ADC_ENABLE = 0;
    localparam int BIT_ADC_POWER_REDUCE = 1;
    localparam int CHAN_LO_LSB = 2;
    localparam int CHAN_LO_MSB = 4;
    localparam int BIT_GLOBAL_IE = 7;

    // ------------------------------------------------------------
    // Interrupt mode codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_TOGGLE = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALL = 2'b10,
        MODE_RISE = 2'b11
    } irq_mode_t;

    localparam logic [2:0] TRIG_RESET = 3'h0;
    localparam logic [2:0] CHAN_LO_RESET = 3'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : cmp_ctrl_pkg

// ==== rtl/cmp_event_if.sv ====
`timescale 1ns/1ns
`default_nettype none

interface cmp_event_if;
    logic result;
    logic toggle;
    logic rise;
    logic fall;

    modport source (output result, output toggle, output rise, output fall);
    modport sink (input result, input toggle, input rise, input fall);
endinterface : cmp_event_if

`default_nettype wire

// ==== rtl/cmp_sync_edge.sv ====
`timescale 1ns/1ns
`default_nettype none

module cmp_sync_edge
    import cmp_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw comparator level
    input wire logic cmp_raw,
    // Synchronised result and events
    cmp_event_if.source ev
);

    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    always_comb begin
        next_meta = cmp_raw;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // Events compare only the second stage with its own history
    assign ev.result = sync;
    assign ev.toggle = sync ^ prev;
    assign ev.rise = sync & ~prev;
    assign ev.fall = ~sync & prev;

endmodule : cmp_sync_edge

`default_nettype wire

// ==== tb/cmp_ctrl_properties.sv ====
`timescale 1ns/1ns
`default_nettype none

module cmp_ctrl_properties
    import cmp_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Comparator side
    input wire logic cmp_raw,
    input wire logic cmp_power_off,
    input wire logic cmp_bandgap_select,
    input wire logic cmp_neg_from_mux,
    input wire logic [3:0] cmp_neg_channel,
    input wire logic cmp_capture_out,
    input wire logic irq_ack,
    input wire logic cmp_irq_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    sequence raw_quiet_s;
        $stable(cmp_raw) && $past(cmp_raw, 2) == cmp_raw && $past(cmp_raw, 3) == cmp_raw;
    endsequence

    chk_one_wait: assert property (setup_s ##1 access_s |-> ##1 pready)
        else $error("ready late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_ready_in_access: assert property (pready |-> access_s)
        else $error("ready outside access");
    chk_err_decode: assert property (pready |-> pslverr == !(paddr == ADDR_CMP_CTRL_STATUS
        || paddr == ADDR_ADC_CTRL_STATUS_B || paddr == ADDR_CMP_AUX_CONTROL))
        else $error("error decode");
    chk_rdata_idle: assert property (!(pready && !pwrite && !pslverr) |-> prdata == RDATA_ZERO)
        else $error("read data not zero");
    chk_config_write: assert property ($changed({cmp_power_off, cmp_bandgap_select, cmp_neg_from_mux,
        cmp_neg_channel}) |-> $past(pready && pwrite && !pslverr))
        else $error("config moved without write");
    chk_capture_delay: assert property ($rose(cmp_capture_out) |-> $past(cmp_raw, 3))
        else $error("capture not from result");
    chk_ack_clears: assert property (irq_ack ##0 raw_quiet_s |-> ##2 !cmp_irq_req)
        else $error("request kept after ack");
    chk_bg_write: assert property ($rose(cmp_bandgap_select) |-> $past(pwrite))
        else $error("bandgap select moved");
endmodule : cmp_ctrl_properties

bind analog_comparator_control cmp_ctrl_properties u_chk (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .cmp_raw, .cmp_power_off, .cmp_bandgap_select,
    .cmp_neg_from_mux, .cmp_neg_channel, .cmp_capture_out, .irq_ack, .cmp_irq_req);

`default_nettype wire

// ==== tb/cmp_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module cmp_core_model (
    // Clock
    input wire logic pclk,
    // Analog stand-ins
    input wire logic pos_pin,
    input wire logic bandgap_above,
    // Controls from the block
    input wire logic power_off,
    input wire logic bandgap_select,
    // Raw output
    output logic cmp_raw
);
    initial cmp_raw = 1'b0;
    // Unpowered core freezes its output, so no edge leaks into the flag
    always @(posedge pclk) begin
        if (!power_off) begin
            cmp_raw <= bandgap_select ? bandgap_above : pos_pin;
        end
    end
endmodule : cmp_core_model

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb
    import cmp_ctrl_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_ack = 1'b0;
    logic [31:0] pwdata = '0, prdata, rdat, r;
    logic pready, pslverr, rerr, cmp_raw, cmp_irq_req, cmp_capture_out;
    logic cmp_power_off, cmp_bandgap_select, cmp_neg_from_mux;
    logic [3:0] cmp_neg_channel;
    logic pos_pin = 1'b0, bandgap_above = 1'b1, lvl = 1'b0;
    logic [ADDR_W-1:0] regs [3] = '{ADDR_CMP_CTRL_STATUS, ADDR_ADC_CTRL_STATUS_B, ADDR_CMP_AUX_CONTROL};
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    integer seed = 92;

    always #4 pclk = ~pclk;

    analog_comparator_control u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .cmp_raw, .cmp_power_off, .cmp_bandgap_select, .cmp_neg_from_mux,
        .cmp_neg_channel, .cmp_capture_out, .irq_ack, .cmp_irq_req);
    cmp_core_model u_core (.pclk, .pos_pin, .bandgap_above, .power_off(cmp_power_off),
        .bandgap_select(cmp_bandgap_select), .cmp_raw);

    function automatic logic exp_flag(input logic [1:0] m, input logic was, input logic now);
        case (m)
            2'b00: return was != now;
            2'b10: return was && !now;
            2'b11: return !was && now;
            default: return 1'b0;
        endcase
    endfunction : exp_flag

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait that never completes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // ------------------------------------------------------------
        // Reset values, unmapped and read-only bits
        // ------------------------------------------------------------
        bus(1'b1, 12'h004, 8'hff);
        check("slverr", rerr, 1);
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h20);
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 8'h00);
            check("reset value", rdat, 0);
        end
        $display("done: registers");
        // ------------------------------------------------------------
        // Every mode against both edges, enable kept off while changing
        // ------------------------------------------------------------
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ADDR_CMP_CTRL_STATUS, {6'h00, m[1:0]});
            bus(1'b1, ADDR_CMP_CTRL_STATUS, {6'h04, m[1:0]});
            for (int k = 0; k < 2; k++) begin
                lvl = !lvl;
                pos_pin <= lvl;
                repeat (6) @(posedge pclk);
                bus(1'b0, ADDR_CMP_CTRL_STATUS, 8'h00);
                check("flag", rdat[4], exp_flag(m[1:0], !lvl, lvl));
                check("result", rdat[5], lvl);
                bus(1'b1, ADDR_CMP_CTRL_STATUS, {6'h04, m[1:0]});
            end
        end
        $display("done: modes");
        // ------------------------------------------------------------
        // Request gating, vector clear, write-one clear
        // ------------------------------------------------------------
        bus(1'b1, ADDR_CMP_AUX_CONTROL, 8'h80);
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h1b);
        pos_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        check("req", cmp_irq_req, 1);
        // Request follows an enable change one cycle after the write lands
        bus(1'b1, ADDR_CMP_AUX_CONTROL, 8'h00);
        @(posedge pclk);
        check("req gated", cmp_irq_req, 0);
        bus(1'b1, ADDR_CMP_AUX_CONTROL, 8'h80);
        @(posedge pclk);
        check("req back", cmp_irq_req, 1);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        check("req after ack", cmp_irq_req, 0);
        pos_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        pos_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h0b);
        bus(1'b0, ADDR_CMP_CTRL_STATUS, 8'h00);
        check("flag kept", rdat[4], 1);
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h1b);
        bus(1'b0, ADDR_CMP_CTRL_STATUS, 8'h00);
        check("flag cleared", rdat[4], 0);
        check("req cleared", cmp_irq_req, 0);
        $display("done: interrupt");
        // ------------------------------------------------------------
        // Power, bandgap and capture route
        // ------------------------------------------------------------
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h03);
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h83);
        check("power off", cmp_power_off, 1);
        bandgap_above <= 1'b0;
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h43);
        check("bandgap", {cmp_bandgap_select, cmp_power_off}, 2'b10);
        repeat (6) @(posedge pclk);
        bus(1'b0, ADDR_CMP_CTRL_STATUS, 8'h00);
        check("bandgap result", rdat[5], 0);
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h04);
        repeat (6) @(posedge pclk);
        check("capture on", cmp_capture_out, 1);
        pos_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        check("capture low", cmp_capture_out, 0);
        pos_pin <= 1'b1;
        bus(1'b1, ADDR_CMP_CTRL_STATUS, 8'h00);
        repeat (6) @(posedge pclk);
        check("capture off", cmp_capture_out, 0);
        $display("done: analog controls");
        // ------------------------------------------------------------
        // Negative input selection, random with swept corners
        // ------------------------------------------------------------
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            if (i < 4) r[2:0] = {1'b1, i[1:0]};
            bus(1'b1, ADDR_ADC_CTRL_STATUS_B, {1'b0, r[2], 2'b00, r[6], r[9:7]});
            bus(1'b1, ADDR_CMP_AUX_CONTROL, {3'b000, r[5:3], r[0], r[1]});
            check("from mux", cmp_neg_from_mux, r[2] && !r[1] && !r[0]);
            check("channel", cmp_neg_channel, r[6:3]);
            bus(1'b0, ADDR_ADC_CTRL_STATUS_B, 8'h00);
            check("adc b", rdat, {1'b0, r[2], 2'b00, r[6], r[9:7]});
        end
        $display("done: mux");
        test_done();
    end
endmodule : tb

`default_nettype wire
